// [verilog/cssu_pkg.sv]
// constants, encodings and timing counts for the clock source select block
// assumes a 100 MHz system clock and fuse levels that are stable at reset
package cssu_pkg;
  // ****************************************************
  // fuse encodings
  // ****************************************************
  localparam logic [3:0] FUSE_SRC_EXT = 4'h0; // external clock pin
  localparam logic [3:0] FUSE_SRC_RC = 4'h2; // calibrated rc, 8.0 MHz
  localparam logic [3:0] FUSE_SRC_LF = 4'h3; // low power 128 kHz
  localparam logic [1:0] SUT_BOD = 2'h0; // 14 ck, plus 4.1 ms on rc or 128 kHz with reset pin disable
  localparam logic [1:0] SUT_FAST = 2'h1; // fast rising power
  localparam logic [1:0] SUT_SLOW = 2'h2; // slowly rising power
  // shipped (blank fuse array) state
  localparam logic [3:0] SHIP_SRC = 4'h2;
  localparam logic [1:0] SHIP_SUT = 2'h2;
  localparam logic SHIP_DIV8 = 1'b1;
  // prescaler start values
  localparam logic [3:0] PRESC_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_DIV8 = 4'h3;
  // trim value before the calibration byte lands
  localparam logic [7:0] TRIM_RST = 8'h00;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CNT_W = 24;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [23:0] BASE_CK = 24'h00_000E; // 14 ck reset part
  localparam logic [23:0] WAKE_CK = 24'h00_0006; // 6 ck wake delay
  localparam int T_4P1MS_NS = 4100000;
  localparam int T_65MS_NS = 65000000;
  localparam int T_4MS_NS = 4000000;
  localparam int T_64MS_NS = 64000000;
  localparam int T_4P1MS_CYC = (T_4P1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_65MS_CYC = (T_65MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_4MS_CYC = (T_4MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_64MS_CYC = (T_64MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************************
  // register map and status fields
  // ****************************************************
  localparam logic [7:0] ADR_TRIM = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam int ST_SRC_LSB = 0; // two bits
  localparam int ST_SUT_LSB = 2; // two bits
  localparam int ST_DIV8_BIT = 4;
  localparam int ST_RSTDIS_BIT = 5;
  localparam int ST_RUN_BIT = 6;
  localparam int ST_BAD_BIT = 7;
  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [1:0] {
    SRC_RC = 2'b00,
    SRC_LF = 2'b01,
    SRC_EXT = 2'b10
  } cssu_src_e;
  typedef enum logic [2:0] {
    ST_LOAD = 3'b000,
    ST_DELAY = 3'b001,
    ST_RUN = 3'b010,
    ST_SLEEP = 3'b011,
    ST_WAKE = 3'b100
  } cssu_state_e;
endpackage

// [verilog/cssu_fuse_latch.sv]
// fuse capture: holds source, startup and option fuses from reset on
// assumes capture is pulsed once, just after reset release
`timescale 1ns/1ps
`default_nettype none
module cssu_fuse_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic capture,
  input wire logic fuse_blank,
  input wire logic [3:0] src_fuse,
  input wire logic [1:0] sut_fuse,
  input wire logic div8_fuse,
  input wire logic rstdis_fuse,
  output cssu_pkg::cssu_src_e src_ff,
  output logic [1:0] sut_ff,
  output logic div8_ff,
  output logic rstdis_ff,
  output logic bad_ff
);
  cssu_pkg::cssu_src_e nxt_src; // decoded source
  logic [1:0] nxt_sut;
  logic nxt_div8;
  logic nxt_rstdis;
  logic nxt_bad; // unsupported source code seen
  logic [3:0] src_code; // fuse or shipped code
  // decode on capture only; values then stay put until the next reset
  always_comb begin
    src_code = fuse_blank ? cssu_pkg::SHIP_SRC : src_fuse;
    nxt_src = src_ff;
    nxt_sut = sut_ff;
    nxt_div8 = div8_ff;
    nxt_rstdis = rstdis_ff;
    nxt_bad = bad_ff;
    if (capture) begin
      nxt_sut = fuse_blank ? cssu_pkg::SHIP_SUT : sut_fuse;
      nxt_div8 = fuse_blank ? cssu_pkg::SHIP_DIV8 : div8_fuse;
      nxt_rstdis = fuse_blank ? 1'b0 : rstdis_fuse;
      nxt_bad = 1'b0;
      if (src_code == cssu_pkg::FUSE_SRC_RC) begin
        nxt_src = cssu_pkg::SRC_RC;
      end else if (src_code == cssu_pkg::FUSE_SRC_LF) begin
        nxt_src = cssu_pkg::SRC_LF;
      end else if (src_code == cssu_pkg::FUSE_SRC_EXT) begin
        nxt_src = cssu_pkg::SRC_EXT;
      end else begin
        // crystal codes are not built here; fall back to rc and flag it
        nxt_src = cssu_pkg::SRC_RC;
        nxt_bad = 1'b1;
      end
    end
  end
  // registers only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_ff <= cssu_pkg::SRC_RC;
      sut_ff <= cssu_pkg::SHIP_SUT;
      div8_ff <= cssu_pkg::SHIP_DIV8;
      rstdis_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      sut_ff <= nxt_sut;
      div8_ff <= nxt_div8;
      rstdis_ff <= nxt_rstdis;
      bad_ff <= nxt_bad;
    end
  end
endmodule
`default_nettype wire

// [verilog/cssu_delay_cnt.sv]
// down counter for start-up delays; done is high in the last counted cycle
// assumes len is at least one; a start while busy reloads the count
`timescale 1ns/1ps
`default_nettype none
module cssu_delay_cnt (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [23:0] len,
  output logic busy,
  output logic done
);
  logic [23:0] cnt_ff; // cycles left
  logic busy_ff; // counting
  logic [23:0] nxt_cnt;
  logic nxt_busy;
  // next count: load on start, step down, stop after the last cycle
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    if (start) begin
      nxt_cnt = len;
      nxt_busy = 1'b1;
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - 24'h00_0001;
      nxt_busy = (cnt_ff != 24'h00_0001);
    end
  end
  // registers only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 24'h00_0000;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end
  assign busy = busy_ff;
  assign done = busy_ff && (cnt_ff == 24'h00_0001);
endmodule
`default_nettype wire

// [verilog/cssu_top.sv]
// clock source select and start-up sequencer with rc trim register
// assumes fuse and calibration inputs are stable while RSTN is low
`timescale 1ns/1ps
`default_nettype none
module cssu_top #(
  parameter int T_4P1MS_CYC = cssu_pkg::T_4P1MS_CYC,
  parameter int T_65MS_CYC = cssu_pkg::T_65MS_CYC,
  parameter int T_4MS_CYC = cssu_pkg::T_4MS_CYC,
  parameter int T_64MS_CYC = cssu_pkg::T_64MS_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // fuses and calibration byte
  input wire logic FUSE_BLANK,
  input wire logic [3:0] CLOCK_SOURCE_FUSES,
  input wire logic [1:0] STARTUP_TIME_FUSES,
  input wire logic DIVIDE_BY_EIGHT_FUSE,
  input wire logic RESET_PIN_DISABLE_FUSE,
  input wire logic [7:0] CAL_BYTE,
  // power-down and power-save handshake
  input wire logic SLEEP_REQ,
  input wire logic WAKE_REQ,
  // classic wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // clock tree controls
  output cssu_pkg::cssu_src_e CLK_SRC_SEL,
  output logic [7:0] RC_TRIM,
  output logic RC_RANGE_HI,
  output logic [6:0] RC_FINE,
  output logic [3:0] PRESCALE_SEL,
  output logic WDOG_ON_WDOSC,
  output logic CORE_RUN
);
  // ****************************************************
  // fuse capture and delay counter
  // ****************************************************
  cssu_pkg::cssu_state_e state_ff; // sequencer state
  cssu_pkg::cssu_state_e nxt_state;
  cssu_pkg::cssu_src_e src_q; // latched source
  logic [1:0] sut_q; // latched startup fuses
  logic div8_q; // latched divide-by-eight fuse
  logic rstdis_q; // latched reset pin disable fuse
  logic bad_q; // unsupported source code
  logic cnt_start; // load delay counter
  logic [23:0] cnt_len; // cycles to count
  logic cnt_busy;
  logic cnt_done; // last delay cycle

  cssu_fuse_latch u_fuse (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .capture(state_ff == cssu_pkg::ST_LOAD),
    .fuse_blank(FUSE_BLANK),
    .src_fuse(CLOCK_SOURCE_FUSES),
    .sut_fuse(STARTUP_TIME_FUSES),
    .div8_fuse(DIVIDE_BY_EIGHT_FUSE),
    .rstdis_fuse(RESET_PIN_DISABLE_FUSE),
    .src_ff(src_q),
    .sut_ff(sut_q),
    .div8_ff(div8_q),
    .rstdis_ff(rstdis_q),
    .bad_ff(bad_q)
  );

  cssu_delay_cnt u_cnt (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .start(cnt_start),
    .len(cnt_len),
    .busy(cnt_busy),
    .done(cnt_done)
  );

  // ****************************************************
  // reset delay table
  // ****************************************************
  // extra ms part by source and startup fuses; reserved 11 takes the
  // longest delay, the safe side for an unknown supply ramp
  function automatic logic [23:0] reset_len(
    input cssu_pkg::cssu_src_e src,
    input logic [1:0] startup_time_fuses,
    input logic rstdis
  );
    logic [23:0] extra;
    extra = 24'h00_0000;
    if (startup_time_fuses == cssu_pkg::SUT_BOD) begin
      // only the rc and 128 kHz sources stretch the bod setting
      if (rstdis && (src != cssu_pkg::SRC_EXT)) begin
        extra = 24'(T_4P1MS_CYC);
      end
    end else if (startup_time_fuses == cssu_pkg::SUT_FAST) begin
      extra = (src == cssu_pkg::SRC_LF) ? 24'(T_4MS_CYC) : 24'(T_4P1MS_CYC);
    end else begin
      extra = (src == cssu_pkg::SRC_LF) ? 24'(T_64MS_CYC) : 24'(T_65MS_CYC);
    end
    return cssu_pkg::BASE_CK + extra;
  endfunction

  // ****************************************************
  // start-up sequencer
  // ****************************************************
  // load -> delay -> run; sleep holds the core, wake waits 6 ck
  always_comb begin
    nxt_state = state_ff;
    cnt_start = 1'b0;
    cnt_len = cssu_pkg::WAKE_CK;
    case (state_ff)
      cssu_pkg::ST_LOAD: begin
        // fuses land this edge; the delay is started from them next
        nxt_state = cssu_pkg::ST_DELAY;
      end
      cssu_pkg::ST_DELAY: begin
        if (!cnt_busy) begin
          cnt_start = 1'b1;
          cnt_len = reset_len(src_q, sut_q, rstdis_q);
        end else if (cnt_done) begin
          nxt_state = cssu_pkg::ST_RUN;
        end
      end
      cssu_pkg::ST_RUN: begin
        if (SLEEP_REQ) begin
          nxt_state = cssu_pkg::ST_SLEEP;
        end
      end
      cssu_pkg::ST_SLEEP: begin
        if (WAKE_REQ) begin
          cnt_start = 1'b1;
          cnt_len = cssu_pkg::WAKE_CK;
          nxt_state = cssu_pkg::ST_WAKE;
        end
      end
      cssu_pkg::ST_WAKE: begin
        if (cnt_done) begin
          nxt_state = cssu_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = cssu_pkg::ST_LOAD;
      end
    endcase
  end

  // registers only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state_ff <= cssu_pkg::ST_LOAD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************
  // clock tree outputs
  // ****************************************************
  cssu_pkg::cssu_src_e src_sel_ff; // drives the source mux
  logic [3:0] presc_ff; // prescaler start value
  logic run_ff; // core clock enabled
  logic wdosc_ff; // watchdog time base select
  cssu_pkg::cssu_src_e nxt_src_sel;
  logic [3:0] nxt_presc;
  logic nxt_run;
  logic nxt_wdosc;

  // source and prescaler follow the fuse latch only right after load
  always_comb begin
    nxt_src_sel = src_sel_ff;
    nxt_presc = presc_ff;
    nxt_run = (nxt_state == cssu_pkg::ST_RUN);
    // watchdog time base never moves off the watchdog oscillator; the reset time-out counts CLK_SYS
    nxt_wdosc = 1'b1;
    if (state_ff == cssu_pkg::ST_DELAY && !cnt_busy) begin
      nxt_src_sel = src_q;
      nxt_presc = div8_q ? cssu_pkg::PRESC_DIV8 : cssu_pkg::PRESC_DIV1;
    end
  end

  // registers only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      src_sel_ff <= cssu_pkg::SRC_RC;
      presc_ff <= cssu_pkg::PRESC_DIV8;
      run_ff <= 1'b0;
      wdosc_ff <= 1'b1;
    end else begin
      src_sel_ff <= nxt_src_sel;
      presc_ff <= nxt_presc;
      run_ff <= nxt_run;
      wdosc_ff <= nxt_wdosc;
    end
  end

  // ****************************************************
  // wishbone slave and trim register
  // ****************************************************
  // ack rises the cycle after the request; the write lands on the edge
  // where the master samples ack, so a held request writes once per ack, on every other cycle
  logic [7:0] trim_ff; // rc trim register
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0] nxt_trim;
  logic nxt_ack;
  logic [31:0] nxt_rdat;
  logic req; // live request
  logic [31:0] status_w; // status word

  always_comb begin
    req = WB_CYC_I && WB_STB_I;
    status_w = 32'h0000_0000;
    status_w[cssu_pkg::ST_SRC_LSB +: 2] = src_sel_ff;
    status_w[cssu_pkg::ST_SUT_LSB +: 2] = sut_q;
    status_w[cssu_pkg::ST_DIV8_BIT] = div8_q;
    status_w[cssu_pkg::ST_RSTDIS_BIT] = rstdis_q;
    status_w[cssu_pkg::ST_RUN_BIT] = run_ff;
    status_w[cssu_pkg::ST_BAD_BIT] = bad_q;
    nxt_ack = req && !ack_ff;
    nxt_rdat = rdat_ff;
    nxt_trim = trim_ff;
    if (req && !ack_ff) begin
      // unmapped offsets still answer, reading zero
      if (WB_ADR_I == cssu_pkg::ADR_TRIM) begin
        nxt_rdat = {24'h00_0000, trim_ff};
      end else if (WB_ADR_I == cssu_pkg::ADR_STATUS) begin
        nxt_rdat = status_w;
      end else begin
        nxt_rdat = 32'h0000_0000;
      end
    end
    if (state_ff == cssu_pkg::ST_LOAD) begin
      nxt_trim = CAL_BYTE;
    end else if (req && ack_ff && WB_WE_I && WB_SEL_I[0]
                 && WB_ADR_I == cssu_pkg::ADR_TRIM) begin
      // new trim goes straight to the oscillator; no eeprom guard here
      nxt_trim = WB_DAT_I[7:0];
    end
  end

  // registers only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      trim_ff <= cssu_pkg::TRIM_RST;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      trim_ff <= nxt_trim;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;
  assign CLK_SRC_SEL = src_sel_ff;
  assign RC_TRIM = trim_ff;
  assign RC_RANGE_HI = trim_ff[7];
  assign RC_FINE = trim_ff[6:0];
  assign PRESCALE_SEL = presc_ff;
  assign WDOG_ON_WDOSC = wdosc_ff;
  assign CORE_RUN = run_ff;

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  logic trim_wr; // helper: a trim write is taken
  assign trim_wr = req && ack_ff && WB_WE_I && WB_SEL_I[0]
                   && WB_ADR_I == cssu_pkg::ADR_TRIM
                   && state_ff != cssu_pkg::ST_LOAD;

  sequence s_wake_req;
    state_ff == cssu_pkg::ST_SLEEP && WAKE_REQ;
  endsequence
  sequence s_wake_wait;
    !CORE_RUN [*6] ##1 CORE_RUN;
  endsequence

  a_trim_cal_load: assert property (
    state_ff == cssu_pkg::ST_LOAD |=> RC_TRIM == $past(CAL_BYTE))
    else $error("trim not loaded from calibration byte");

  a_src_rc_sel: assert property (
    (state_ff == cssu_pkg::ST_LOAD && !FUSE_BLANK
     && CLOCK_SOURCE_FUSES == cssu_pkg::FUSE_SRC_RC)
    |=> ##2 CLK_SRC_SEL == cssu_pkg::SRC_RC)
    else $error("rc fuse code did not select rc");

  a_wake_six_ck: assert property (
    s_wake_req |-> ##1 s_wake_wait)
    else $error("wake delay not six cycles");

  a_rstdis_stretch: assert property (
    (state_ff == cssu_pkg::ST_DELAY && !cnt_busy && rstdis_q
     && sut_q == cssu_pkg::SUT_BOD && src_q != cssu_pkg::SRC_EXT)
    |-> cnt_len == cssu_pkg::BASE_CK + 24'(T_4P1MS_CYC))
    else $error("reset pin disable did not stretch delay");

  a_wdog_wdosc: assert property (
    ##1 WDOG_ON_WDOSC)
    else $error("watchdog time base moved");

  a_trim_write: assert property (
    trim_wr |=> RC_TRIM == $past(WB_DAT_I[7:0]) && !WB_ACK_O)
    else $error("trim write not applied");

  a_lf_sel: assert property (
    (state_ff == cssu_pkg::ST_LOAD && !FUSE_BLANK
     && CLOCK_SOURCE_FUSES == cssu_pkg::FUSE_SRC_LF)
    |=> ##2 CLK_SRC_SEL == cssu_pkg::SRC_LF)
    else $error("128 kHz code did not select low power source");

  a_ext_sel: assert property (
    (state_ff == cssu_pkg::ST_LOAD && !FUSE_BLANK
     && CLOCK_SOURCE_FUSES == cssu_pkg::FUSE_SRC_EXT)
    |=> ##2 CLK_SRC_SEL == cssu_pkg::SRC_EXT)
    else $error("external code did not select clock pin");

  a_div8_start: assert property (
    (state_ff == cssu_pkg::ST_DELAY && cnt_busy)
    |-> PRESCALE_SEL == (div8_q ? cssu_pkg::PRESC_DIV8 : cssu_pkg::PRESC_DIV1))
    else $error("prescaler start value wrong");

  a_ship_default: assert property (
    (state_ff == cssu_pkg::ST_LOAD && FUSE_BLANK)
    |=> src_q == cssu_pkg::SRC_RC && sut_q == cssu_pkg::SUT_SLOW && div8_q)
    else $error("blank fuses did not give shipped setting");

  a_src_fixed: assert property (
    ($past(state_ff) != cssu_pkg::ST_DELAY || $past(cnt_busy))
    |-> $stable(CLK_SRC_SEL))
    else $error("clock source changed after start-up");

  a_ack_one: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// [test/cssu_fuse_src.sv]
// fuse array and calibration byte model on the far side of the block
// assumes the bench changes cfg while reset is low, or on purpose while running
`timescale 1ns/1ps
`default_nettype none
module cssu_fuse_src (
  input wire logic [16:0] cfg,
  output logic fuse_blank,
  output logic [3:0] src,
  output logic [1:0] startup_time_fuses,
  output logic div8,
  output logic rstdis,
  output logic [7:0] cal
);
  // fuses are static levels; the only clock source is the bench clock,
  // whose period never moves, so it stays inside the 2 percent step limit
  assign {fuse_blank, src, startup_time_fuses, div8, rstdis, cal} = cfg;
endmodule
`default_nettype wire

// [test/cssu_top_bench.sv]
// self-checking bench for the clock source select block
// assumes the design files and the fuse model are compiled first
`timescale 1ns/1ps
`default_nettype none
module cssu_top_bench;
  // shortened millisecond counts keep the run small
  localparam int TA = 20;
  localparam int TB = 40;
  localparam int TC = 18;
  localparam int TD = 36;
  // cfg: blank, source, startup, div8, reset pin disable, calibration
  // last entry: unsupported source code and reserved startup code
  localparam logic [16:0] CFG [10] = '{
    {1'b0, 4'h2, 2'h0, 2'b00, 8'h5A}, {1'b0, 4'h2, 2'h1, 2'b00, 8'hA5},
    {1'b0, 4'h2, 2'h0, 2'b11, 8'h3C}, {1'b0, 4'h3, 2'h1, 2'b00, 8'h11},
    {1'b0, 4'h3, 2'h2, 2'b00, 8'h7E}, {1'b0, 4'h3, 2'h0, 2'b01, 8'h81},
    {1'b0, 4'h0, 2'h2, 2'b00, 8'hF0}, {1'b0, 4'h0, 2'h0, 2'b01, 8'h0F},
    {1'b1, 4'h0, 2'h0, 2'b00, 8'hC3}, {1'b0, 4'h7, 2'h3, 2'b00, 8'h69}};
  localparam int LEN [10] = '{14, 14 + TA, 14 + TA, 14 + TC, 14 + TD,
    14 + TA, 14 + TB, 14, 14 + TB, 14 + TB};
  localparam logic [1:0] SRCX [10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0,
    2'h0};
  logic clk_sys, rstn, sleep_req, wake_req, cyc, stb, we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd, st;
  logic [16:0] cfg;
  logic fuse_blank, div8, rstdis, ack, range_hi, wdog, core_run;
  logic [3:0] src_f, presc;
  logic [1:0] sut_f;
  logic [7:0] cal, trim;
  logic [6:0] fine;
  cssu_pkg::cssu_src_e clk_src;
  int mismatches = 0;
  int checks_done = 0;

  cssu_fuse_src cssu_fuse_src_i (.cfg(cfg), .fuse_blank(fuse_blank), .src(src_f),
    .startup_time_fuses(sut_f), .div8(div8), .rstdis(rstdis), .cal(cal));
  cssu_top #(.T_4P1MS_CYC(TA), .T_65MS_CYC(TB), .T_4MS_CYC(TC), .T_64MS_CYC(TD))
  cssu_top_i (.CLK_SYS(clk_sys), .RSTN(rstn), .FUSE_BLANK(fuse_blank),
    .CLOCK_SOURCE_FUSES(src_f), .STARTUP_TIME_FUSES(sut_f), .DIVIDE_BY_EIGHT_FUSE(div8),
    .RESET_PIN_DISABLE_FUSE(rstdis), .CAL_BYTE(cal), .SLEEP_REQ(sleep_req),
    .WAKE_REQ(wake_req), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CLK_SRC_SEL(clk_src), .RC_TRIM(trim), .RC_RANGE_HI(range_hi), .RC_FINE(fine),
    .PRESCALE_SEL(presc), .WDOG_ON_WDOSC(wdog), .CORE_RUN(core_run));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic give_up;
    mismatches++;
    finish_test();
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; entered just after a rising edge, leaves cyc low one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) give_up();
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask

  // reset with one fuse setting and time the start-up
  task automatic boot(input int k);
    int n;
    logic [3:0] pexp; // expected prescaler start value
    rstn <= 1'b0;
    cfg <= CFG[k];
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (core_run !== 1'b1 && n < 200);
    if (core_run !== 1'b1) give_up();
    chk("start delay", n, LEN[k] + 3);
    chk("source", clk_src, SRCX[k]);
    pexp = (cfg[9] | cfg[16]) ? cssu_pkg::PRESC_DIV8 : cssu_pkg::PRESC_DIV1;
    chk("prescale", presc, pexp);
    chk("trim load", trim, cfg[7:0]);
    chk("watchdog osc", wdog, 1'b1);
  endtask

  // power-down then wake; the core must stay halted six cycles
  task automatic nap;
    int n;
    sleep_req <= 1'b1;
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    @(posedge clk_sys);
    chk("asleep", core_run, 1'b0);
    wake_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      wake_req <= 1'b0;
      n++;
    end while (core_run !== 1'b1 && n < 50);
    if (core_run !== 1'b1) give_up();
    // run rises on the sixth edge after the wake edge and is seen one edge later
    chk("wake delay", n, 8);
  endtask

  // ****************************************************
  // stimulus
  // ****************************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    rstn = 1'b0;
    cfg = CFG[0];
    {sleep_req, wake_req, cyc, stb, we} = 5'b00000;
    adr = 8'h00;
    sel = 4'h0;
    dat_i = 32'h0000_0000;
    @(posedge clk_sys);
    for (int k = 0; k < 10; k++) begin
      boot(k);
      nap();
    end
    // trim across the range boundary; any written value is taken as is
    wb(1'b1, cssu_pkg::ADR_TRIM, 4'h1, 32'h0000_007F, rd);
    chk("trim", trim, 8'h7F);
    chk("range", range_hi, 1'b0);
    chk("fine", fine, 7'h7F);
    wb(1'b0, cssu_pkg::ADR_TRIM, 4'hF, 32'h0000_0000, rd);
    chk("trim read", rd, 32'h0000_007F);
    wb(1'b1, cssu_pkg::ADR_TRIM, 4'h1, 32'h0000_0080, rd);
    chk("range", range_hi, 1'b1);
    chk("fine", fine, 7'h00);
    // a write without the low byte lane is dropped
    wb(1'b1, cssu_pkg::ADR_TRIM, 4'h0, 32'h0000_0011, rd);
    chk("trim lane", trim, 8'h80);
    wb(1'b0, 8'h08, 4'hF, 32'h0000_0000, rd);
    chk("unmapped", rd, 32'h0000_0000);
    // status is read only
    wb(1'b0, cssu_pkg::ADR_STATUS, 4'hF, 32'h0000_0000, st);
    chk("run bit", st[cssu_pkg::ST_RUN_BIT], 1'b1);
    // last boot: rc fallback, startup 11, no divide, running, bad code flagged
    chk("status word", st, 32'h0000_00CC);
    wb(1'b1, cssu_pkg::ADR_STATUS, 4'hF, 32'h0000_00FF, rd);
    wb(1'b0, cssu_pkg::ADR_STATUS, 4'hF, 32'h0000_0000, rd);
    chk("status", rd, st);
    // fuses moving while running change nothing
    cfg <= CFG[6];
    repeat (4) @(posedge clk_sys);
    chk("held source", clk_src, 2'h0);
    chk("held trim", trim, 8'h80);
    finish_test();
  end
endmodule
`default_nettype wire
